/* File: ptmr_cfg.svh */
// Constants for the 8-bit period timer: register offsets, field positions, reset values.
// Assumes a 32-bit APB slave with one register per aligned word.
`ifndef PTMR_CFG_SVH
`define PTMR_CFG_SVH
`define PTMR_OFF_CONTROL 12'h000
`define PTMR_OFF_COUNT 12'h004
`define PTMR_OFF_PERIOD 12'h008
`define PTMR_OFF_FLAGS 12'h00c
`define PTMR_OFF_ENABLE 12'h010
`define PTMR_OFF_PRIORITY 12'h014
`define PTMR_CTL_RUN_BIT 2
`define PTMR_CTL_PRE_LSB 0
`define PTMR_CTL_POST_LSB 3
`define PTMR_CTL_MASK 8'h7f
`define PTMR_IRQ_BIT 3
`define PTMR_PERIOD_RST 8'hff
`define PTMR_COUNT_RST 8'h00
`define PTMR_CTL_RST 8'h00
`define PTMR_PRE_DIV4 2'h1
`define PTMR_PRE_LAST1 4'h0
`define PTMR_PRE_LAST4 4'h3
`define PTMR_PRE_LAST16 4'hf
`endif

/* File: ptmr_pkg.sv */
// Types shared by the period timer modules.
// Assumes the constants header is included where offsets are needed.
package ptmr_pkg;
  // APB request as seen by the slave
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } ptmr_apb_req_t;
  // Register write strobes decoded from the bus
  typedef struct packed {
    logic ctl;
    logic cnt;
    logic per;
    logic flg;
    logic ena;
    logic pri;
    logic [7:0] data;
  } ptmr_wr_t;
endpackage : ptmr_pkg

/* File: ptmr_postscaler.sv */
// Postscaler: passes one out of N match events, N = select + 1.
// Assumes match pulses are single cycles.
`timescale 1ns/1ps
`default_nettype none
module ptmr_postscaler
  import ptmr_pkg::*;
(
  input wire logic sys_clk, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic clr, // Restart the count
  input wire logic match, // Period match event
  input wire logic [3:0] sel, // Postscale select
  output logic done // One-cycle pulse after N matches
);
  typedef struct packed {
    logic [3:0] cnt;
  } ptmr_post_state_t;
  ptmr_post_state_t state_reg, state_next;

  // Count matches; a clear drops any match in the same cycle
  always_comb begin
    state_next = state_reg;
    done = 1'b0;
    if (clr) begin
      state_next.cnt = 4'h0;
    end else if (match) begin
      if (state_reg.cnt >= sel) begin
        done = 1'b1;
        state_next.cnt = 4'h0;
      end else begin
        state_next.cnt = state_reg.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
endmodule : ptmr_postscaler
`default_nettype wire

/* File: ptmr_prescaler.sv */
// Prescaler: divides the instruction clock by 1, 4 or 16 into a tick.
// Assumes a clear strobe from the register block whenever scaler state must restart.
`timescale 1ns/1ps
`default_nettype none
module ptmr_prescaler
  import ptmr_pkg::*;
(
  input wire logic sys_clk, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic run, // Counting allowed
  input wire logic clr, // Restart the divider
  input wire logic [1:0] sel, // Prescale select
  output logic tick // One-cycle tick towards the counter
);
  `include "ptmr_cfg.svh"
  typedef struct packed {
    logic [3:0] cnt;
  } ptmr_pre_state_t;
  ptmr_pre_state_t state_reg, state_next;
  logic [3:0] lastVal; // Terminal count for the selected ratio

  // Ratio decode
  always_comb begin
    if (sel[1]) begin
      lastVal = `PTMR_PRE_LAST16;
    end else if (sel == `PTMR_PRE_DIV4) begin
      lastVal = `PTMR_PRE_LAST4;
    end else begin
      lastVal = `PTMR_PRE_LAST1;
    end
  end

  // Divider count; tick when terminal count is reached while running
  always_comb begin
    state_next = state_reg;
    tick = 1'b0;
    if (clr) begin
      state_next.cnt = 4'h0;
    end else if (run) begin
      if (state_reg.cnt >= lastVal) begin
        tick = 1'b1;
        state_next.cnt = 4'h0;
      end else begin
        state_next.cnt = state_reg.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
endmodule : ptmr_prescaler
`default_nettype wire

/* File: ptmr_pwm_sink.sv */
// Model of the PWM unit that consumes the unscaled match pulse and watches the irq line.
// Assumes one clock shared with the timer; clr restarts all measurements.
`timescale 1ns/1ps
`default_nettype none
module ptmr_pwm_sink (
  input wire logic sys_clk, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic clr, // Restart measurements
  input wire logic pwmTimeBase, // Time base pulse from the timer
  input wire logic irq, // Interrupt level from the timer
  output logic [15:0] gap, // Cycles between the last two pulses
  output logic [7:0] pulses, // Pulses since clr
  output logic [7:0] pulsesAtIrq // Pulses seen when irq rose
);
  logic [15:0] sinceReg; // Cycles since the last pulse
  logic seenReg; // Irq of the previous cycle
  // Time base use only: a period is the spacing of pulses
  always_ff @(posedge sys_clk) begin
    if (rst || clr) begin
      sinceReg <= 16'h0000;
      gap <= 16'h0000;
      pulses <= 8'h00;
      pulsesAtIrq <= 8'h00;
      seenReg <= 1'b0;
    end else begin
      sinceReg <= pwmTimeBase ? 16'h0000 : sinceReg + 16'h0001;
      // Count the pulse of this cycle too, since flag and pulse may coincide
      if (pwmTimeBase) begin
        gap <= sinceReg + 16'h0001;
        pulses <= pulses + 8'h01;
      end
      seenReg <= irq;
      if (irq && !seenReg) begin
        pulsesAtIrq <= pulses + {7'h00, pwmTimeBase};
      end
    end
  end
endmodule : ptmr_pwm_sink
`default_nettype wire

/* File: ptmr_tb.sv */
// Self-checking bench for the period timer: APB tasks and call sequences.
// Assumes the design answers within a few cycles; every wait is bounded.
`timescale 1ns/1ps
`default_nettype none
`include "ptmr_cfg.svh"
`define CHK(nm, e, g) begin samplesChecked++; if ((g) !== (e)) begin \
  $display("ERROR %s expected %h seen %h", nm, e, g); miscompares++; end end
module tb;
  import ptmr_pkg::*;
  logic sys_clk = 1'b0; // 50 MHz clock
  logic rst = 1'b1; // Reset, held at start
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB controls
  logic [11:0] paddr = 12'h000; // APB address
  logic [31:0] pwdata = 32'h0, prdata, rd; // Write data, read data, last read
  logic pready, pslverr, pwmTimeBase, irq, irqPriority, err; // Design outputs, last error
  logic sinkClr = 1'b0; // Restart of the partner's measurements
  logic [15:0] gap; // Measured pulse spacing
  logic [7:0] pulses, pulsesAtIrq; // Pulse counts
  int miscompares = 0, samplesChecked = 0; // Verdict counters
  int n, p; // Loop helpers
  int expGap[4] = '{3, 12, 48, 48}; // Period 2 gives 3 ticks; ticks of 1, 4, 16, 16 cycles
  ptmr_timer ptmr_timer_i (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pwmTimeBase(pwmTimeBase), .irq(irq), .irqPriority(irqPriority));
  ptmr_pwm_sink ptmr_pwm_sink_i (.sys_clk(sys_clk), .rst(rst), .clr(sinkClr),
    .pwmTimeBase(pwmTimeBase), .irq(irq), .gap(gap), .pulses(pulses), .pulsesAtIrq(pulsesAtIrq));
  // Free-running clock
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  // Verdict and end of run
  task give_verdict;
    if (miscompares == 0 && samplesChecked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  // One APB transfer; mark restarts the partner at the setup edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic mark);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    sinkClr <= mark;
    @(posedge sys_clk);
    penable <= 1'b1;
    sinkClr <= 1'b0;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
    // A hung slave ends the run
    if (k >= 50) begin
      miscompares++;
      give_verdict();
    end
  endtask : apb
  // Read and compare the low byte of a register
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00, 1'b0);
    `CHK("register", {24'h0, e}, rd)
  endtask : rchk
  // Bounded wait for irq (useIrq high) or for two partner pulses, a full period (useIrq low)
  task automatic waitHigh(input logic useIrq);
    for (n = 0; n < 300 && (useIrq ? irq : (pulses >= 8'h02)) !== 1'b1; n++) @(posedge sys_clk);
    if ((useIrq ? irq : (pulses >= 8'h02)) !== 1'b1) begin
      miscompares++;
      give_verdict();
    end
  endtask : waitHigh
  // Main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rchk(`PTMR_OFF_CONTROL, 8'h00);
    rchk(`PTMR_OFF_COUNT, 8'h00);
    rchk(`PTMR_OFF_PERIOD, 8'hff);
    rchk(`PTMR_OFF_FLAGS, 8'h00);
    apb(1'b0, 12'h020, 8'h00, 1'b0);
    `CHK("unmapped", 2'b10, {err, rd[0]})
    apb(1'b1, `PTMR_OFF_CONTROL, 8'h80, 1'b0);
    rchk(`PTMR_OFF_CONTROL, 8'h00);
    apb(1'b1, `PTMR_OFF_PERIOD, 8'h02, 1'b0);
    rchk(`PTMR_OFF_PERIOD, 8'h02);
    // Every prescale code, spacing of the match pulse
    for (p = 0; p < 4; p++) begin
      apb(1'b1, `PTMR_OFF_CONTROL, 8'h04 | p[7:0], 1'b1);
      waitHigh(1'b0);
      `CHK("gap", expGap[p][15:0], gap)
    end
    // Count write while running at divide 16 lands; stop then holds it; control write keeps it
    apb(1'b1, `PTMR_OFF_COUNT, 8'h01, 1'b0);
    apb(1'b1, `PTMR_OFF_CONTROL, 8'h00, 1'b0);
    repeat (40) @(posedge sys_clk);
    rchk(`PTMR_OFF_COUNT, 8'h01);
    apb(1'b1, `PTMR_OFF_CONTROL, 8'h7b, 1'b0);
    rchk(`PTMR_OFF_COUNT, 8'h01);
    rchk(`PTMR_OFF_CONTROL, 8'h7b);
    // Postscale 1:1 during the runs above left the flag set; clear it first
    rchk(`PTMR_OFF_FLAGS, 8'h08);
    apb(1'b1, `PTMR_OFF_FLAGS, 8'h00, 1'b0);
    // Postscale 1:4 sets the flag on the fourth match; the partner latches its count one edge later
    apb(1'b1, `PTMR_OFF_ENABLE, 8'h08, 1'b0);
    apb(1'b1, `PTMR_OFF_CONTROL, 8'h1c, 1'b1);
    waitHigh(1'b1);
    @(posedge sys_clk);
    `CHK("matches", 8'h04, pulsesAtIrq)
    apb(1'b1, `PTMR_OFF_CONTROL, 8'h18, 1'b0);
    rchk(`PTMR_OFF_FLAGS, 8'h08);
    apb(1'b1, `PTMR_OFF_ENABLE, 8'h00, 1'b0);
    `CHK("masked", 1'b0, irq)
    apb(1'b1, `PTMR_OFF_ENABLE, 8'h08, 1'b0);
    `CHK("unmasked", 1'b1, irq)
    apb(1'b1, `PTMR_OFF_FLAGS, 8'h00, 1'b0);
    `CHK("cleared", 1'b0, irq)
    apb(1'b1, `PTMR_OFF_PRIORITY, 8'h08, 1'b0);
    `CHK("priority", 1'b1, irqPriority)
    give_verdict();
  end
endmodule : tb
`default_nettype wire

/* File: ptmr_timer.sv */
// Top of the 8-bit period timer with APB register access and level interrupt.
// Assumes APB master per AMBA; pready answers in the access cycle (no wait states).
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Count only while run bit set
// - Prescale 1, 4 or 16 by low bits
// - Postscale ratio is field plus one
// - Postscaler completion sets latched flag bit
// - Count to period, then wrap to zero
// - Period resets to all ones, read/write
// - Count read/write, cleared by reset
// - Scalers clear on count/control write, reset
// - Control write leaves count unchanged
// - Export unscaled match as PWM time base
// - Control bit7 reads zero, resets zero
module ptmr_timer
  import ptmr_pkg::*;
(
  input wire logic sys_clk, // System clock, 50 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction, 1 = write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  output logic pwmTimeBase, // Unscaled period match pulse
  output logic irq, // Level interrupt
  output logic irqPriority // Priority bit for the interrupt
);
  `include "ptmr_cfg.svh"

  // Register map, one byte in the low lane of each 32-bit word:
  //   control  - run, prescale select and postscale select; bit 7 always reads zero
  //   count    - the 8-bit counter, writable at any time, also while running
  //   period   - wrap point of the counter, all ones after reset
  //   flags    - bit 3 is the latched postscale flag; the other bits are plain storage
  //   enable   - bit 3 lets the flag through to irq
  //   prio     - bit 3 is passed out on irqPriority for the core's arbiter
  // Unmapped words read as zero and answer with pslverr.

  // All module state in one struct
  typedef struct packed {
    logic [7:0] control;
    logic [7:0] count;
    logic [7:0] period;
    logic [7:0] flags;
    logic [7:0] enable;
    logic [7:0] prio; // Bit 3 drives irqPriority
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic match;
    logic irq;
  } ptmr_state_t;
  ptmr_state_t state_reg, state_next;

  // Bus side decode and scaler handshakes
  ptmr_apb_req_t req; // Bundled bus request
  ptmr_wr_t wr; // Decoded write strobes
  logic setup; // Setup phase of a transfer
  logic mapped; // Address hits a register
  logic scalerClr; // Clears both scalers
  logic preTick; // Prescaled increment
  logic matchNow; // Count equals period on an increment
  logic postDone; // Postscaler completion

  // Address decode shared by read and write paths
  function automatic logic isReg(input logic [11:0] a);
    isReg = (a == `PTMR_OFF_CONTROL) || (a == `PTMR_OFF_COUNT) || (a == `PTMR_OFF_PERIOD) ||
            (a == `PTMR_OFF_FLAGS) || (a == `PTMR_OFF_ENABLE) || (a == `PTMR_OFF_PRIORITY);
  endfunction : isReg

  assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
  // Bus timing: a write lands and a read is captured at the setup edge, so the answer is
  // registered and stands for exactly the access cycle. The slave never adds wait states;
  // the trade is that a register read returns the value of the setup cycle.
  // Act in the setup cycle so the answer is registered for the access cycle
  assign setup = req.sel && !req.enable;
  assign mapped = isReg(req.addr);

  // Write strobes, one cycle at the setup phase of a write
  always_comb begin
    wr.data = req.wdata[7:0];
    wr.ctl = setup && req.write && (req.addr == `PTMR_OFF_CONTROL);
    wr.cnt = setup && req.write && (req.addr == `PTMR_OFF_COUNT);
    wr.per = setup && req.write && (req.addr == `PTMR_OFF_PERIOD);
    wr.flg = setup && req.write && (req.addr == `PTMR_OFF_FLAGS);
    wr.ena = setup && req.write && (req.addr == `PTMR_OFF_ENABLE);
    wr.pri = setup && req.write && (req.addr == `PTMR_OFF_PRIORITY);
  end

  assign scalerClr = wr.ctl || wr.cnt;

  // Prescaler gated by the run bit
  ptmr_prescaler u_pre (
    .sys_clk(sys_clk),
    .rst(rst),
    .run(state_reg.control[`PTMR_CTL_RUN_BIT]),
    .clr(scalerClr),
    .sel(state_reg.control[`PTMR_CTL_PRE_LSB +: 2]),
    .tick(preTick)
  );

  // The compare is made only on a tick, so a period written below the running count lets
  // the counter run on to ff and wrap through zero before it can match again.
  assign matchNow = preTick && (state_reg.count == state_reg.period);

  // A count write drops the match of its cycle; the same write restarts the postscaler,
  // so that match could never have counted towards the next flag anyway.
  // Postscaler counts period matches
  ptmr_postscaler u_post (
    .sys_clk(sys_clk),
    .rst(rst),
    .clr(scalerClr),
    .match(matchNow && !wr.cnt),
    .sel(state_reg.control[`PTMR_CTL_POST_LSB +: 4]),
    .done(postDone)
  );

  // Next-state logic for registers, counter, flag and bus answer
  // Priority inside one cycle: a count write beats a tick, a hardware flag set beats a
  // software write of the flags register, and a control write touches only control.
  // Every register not named below keeps its value.
  always_comb begin
    state_next = state_reg;
    state_next.match = 1'b0;
    // Counter: a write wins over an increment in the same cycle
    if (wr.cnt) begin
      state_next.count = wr.data;
    end else if (preTick) begin
      if (matchNow) begin
        state_next.count = 8'h00;
        state_next.match = 1'b1;
      end else begin
        state_next.count = state_reg.count + 8'h01;
      end
    end
    // Control write touches no count bits
    if (wr.ctl) begin
      state_next.control = wr.data & `PTMR_CTL_MASK;
    end
    if (wr.per) begin
      state_next.period = wr.data;
    end
    if (wr.ena) begin
      state_next.enable = wr.data;
    end
    if (wr.pri) begin
      state_next.prio = wr.data;
    end
    // Flags: software writes directly; hardware set wins over a clear
    // A completion that meets a scaler clear is dropped, since the restart begins a new
    // sequence of matches; a flags write never hides a completion of the same cycle.
    if (wr.flg) begin
      state_next.flags = wr.data;
    end
    if (postDone && !scalerClr) begin
      state_next.flags[`PTMR_IRQ_BIT] = 1'b1;
    end
    state_next.irq = state_next.flags[`PTMR_IRQ_BIT] && state_next.enable[`PTMR_IRQ_BIT];
    // Bus answer: registered, valid in the access cycle
    state_next.ready = setup;
    state_next.err = setup && !mapped;
    state_next.rdata = 32'h0000_0000;
    if (setup && !req.write) begin
      unique case (req.addr)
        `PTMR_OFF_CONTROL: state_next.rdata = {24'h000000, state_reg.control & `PTMR_CTL_MASK};
        `PTMR_OFF_COUNT: state_next.rdata = {24'h000000, state_reg.count};
        `PTMR_OFF_PERIOD: state_next.rdata = {24'h000000, state_reg.period};
        `PTMR_OFF_FLAGS: state_next.rdata = {24'h000000, state_reg.flags};
        `PTMR_OFF_ENABLE: state_next.rdata = {24'h000000, state_reg.enable};
        `PTMR_OFF_PRIORITY: state_next.rdata = {24'h000000, state_reg.prio};
        default: state_next.rdata = 32'h0000_0000; // Unmapped reads as zero
      endcase
    end
  end

  // State register with reset values
  // The scalers reset inside their own modules, so a reset also restarts both of them
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= '0;
      state_reg.control <= `PTMR_CTL_RST;
      state_reg.count <= `PTMR_COUNT_RST;
      state_reg.period <= `PTMR_PERIOD_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs come straight from the state register, so none of them can glitch
  assign prdata = state_reg.rdata;
  assign pready = state_reg.ready;
  assign pslverr = state_reg.err;
  assign pwmTimeBase = state_reg.match;
  assign irq = state_reg.irq;
  assign irqPriority = state_reg.prio[`PTMR_IRQ_BIT];

  // Checks next to the logic they guard
  // All of them watch registered state or decoded strobes of this one clock, and all are
  // off while reset is held, so a reset value is never compared with a value from before it.
  // Bus inputs appear only as the byte that a write strobe stores.

  // A stopped timer keeps its count unless software writes it
  a_run_holds: assert property (@(posedge sys_clk) disable iff (rst)
    !state_reg.control[`PTMR_CTL_RUN_BIT] && !wr.cnt |=> $stable(state_reg.count))
    else $error("count moved while stopped");

  // A match on a tick wraps to zero and raises the time base
  a_wrap_zero: assert property (@(posedge sys_clk) disable iff (rst)
    matchNow && !wr.cnt |=> state_reg.count == 8'h00 && pwmTimeBase)
    else $error("no wrap at period match");

  // Divide by 16 leaves at least eight quiet cycles after a tick
  a_pre_div16: assert property (@(posedge sys_clk) disable iff (rst)
    preTick && state_reg.control[1] && !scalerClr |=> !preTick [*8])
    else $error("prescale 16 ticked early");

  // A postscale completion latches the flag
  a_flag_set: assert property (@(posedge sys_clk) disable iff (rst)
    postDone && !scalerClr |=> state_reg.flags[`PTMR_IRQ_BIT])
    else $error("flag not set on postscale");

  // The flag survives every cycle without a flags write
  a_flag_sticky: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg.flags[`PTMR_IRQ_BIT] && !wr.flg |=> state_reg.flags[`PTMR_IRQ_BIT])
    else $error("flag dropped without write");

  // The interrupt line follows flag and enable one for one
  a_irq_level: assert property (@(posedge sys_clk) disable iff (rst)
    irq == (state_reg.flags[`PTMR_IRQ_BIT] && state_reg.enable[`PTMR_IRQ_BIT]))
    else $error("irq mismatch");

  // A control write leaves the count alone
  a_ctl_keeps: assert property (@(posedge sys_clk) disable iff (rst)
    wr.ctl && !preTick |=> state_reg.count == $past(state_reg.count))
    else $error("control write changed count");

  // A count write stores the written byte, even against a tick
  a_cnt_write: assert property (@(posedge sys_clk) disable iff (rst)
    wr.cnt |=> state_reg.count == $past(pwdata[7:0]))
    else $error("count write lost");

  // The unimplemented control bit never holds a one
  a_bit7_zero: assert property (@(posedge sys_clk) disable iff (rst)
    !state_reg.control[7])
    else $error("control bit 7 set");

  // A scaler clear leaves at most a divide-by-one tick in the next cycle
  a_clr_scalers: assert property (@(posedge sys_clk) disable iff (rst)
    scalerClr |=> !preTick || state_reg.control[1:0] == 2'h0)
    else $error("prescaler not cleared");

  // Divide by one ticks on every running cycle without a scaler clear
  a_div1_every: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg.control[`PTMR_CTL_RUN_BIT] && state_reg.control[1:0] == 2'h0 && !scalerClr |-> preTick)
    else $error("prescale 1 missed a tick");

  // A stopped timer never ticks
  a_stop_tick: assert property (@(posedge sys_clk) disable iff (rst)
    !state_reg.control[`PTMR_CTL_RUN_BIT] |-> !preTick)
    else $error("tick while stopped");

  // Postscale 1:1 completes on every counted match
  a_post_div1: assert property (@(posedge sys_clk) disable iff (rst)
    matchNow && !scalerClr && state_reg.control[`PTMR_CTL_POST_LSB +: 4] == 4'h0 |-> postDone)
    else $error("postscale 1 missed a match");

  // A completion only ever comes with a period match
  a_post_gate: assert property (@(posedge sys_clk) disable iff (rst)
    postDone |-> matchNow)
    else $error("completion without match");

  // Short of the period the count steps by one per tick
  a_count_step: assert property (@(posedge sys_clk) disable iff (rst)
    preTick && !wr.cnt && !matchNow |=> state_reg.count == $past(state_reg.count) + 8'h01)
    else $error("count did not step");

  // The time base pulse comes with a count of zero
  a_match_zero: assert property (@(posedge sys_clk) disable iff (rst)
    pwmTimeBase |-> state_reg.count == 8'h00)
    else $error("time base off zero");

  // A period write stores the written byte
  a_per_write: assert property (@(posedge sys_clk) disable iff (rst)
    wr.per |=> state_reg.period == $past(wr.data))
    else $error("period write lost");

  // A control write stores the byte with bit 7 dropped
  a_ctl_write: assert property (@(posedge sys_clk) disable iff (rst)
    wr.ctl |=> state_reg.control == ($past(wr.data) & `PTMR_CTL_MASK))
    else $error("control write lost");

  // Writing a zero clears the flag unless a completion meets it
  a_flag_clear: assert property (@(posedge sys_clk) disable iff (rst)
    wr.flg && !wr.data[`PTMR_IRQ_BIT] && !postDone |=> !state_reg.flags[`PTMR_IRQ_BIT])
    else $error("flag not cleared by write");
endmodule : ptmr_timer
`default_nettype wire
